//--- ssg_pkg.sv
// constants, field positions and carrier types of the spindle select and gear sequencer
// assumes one 40 MHz clock and a word-indexed register port of 16-bit data
package ssg_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register word indexes
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SHIFT_SPEED = 4'h1;
    localparam logic [3:0] REG_TMR_FIRST = 4'h2;
    localparam logic [3:0] REG_TMR_SECOND = 4'h3;
    localparam logic [3:0] REG_TMR_CHECK = 4'h4;
    localparam logic [3:0] REG_GMAX_FIRST = 4'h5;
    localparam logic [3:0] REG_GMAX_LAST = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    localparam logic [3:0] REG_ALARM = 4'ha;

    // control register fields
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int CTRL_ANALOG_BIT = 2;
    localparam int CTRL_BLOCK_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h4;

    // alarm register fields
    localparam int ALM_DIR_BIT = 0;
    localparam int ALM_WRONG_BIT = 1;
    localparam int ALM_TIMEOUT_BIT = 2;
    localparam int ALM_DISABLED_BIT = 3;

    // values after reset, timers in milliseconds
    localparam logic [11:0] SHIFT_SPEED_RST = 12'h200;
    localparam logic [15:0] TMR_FIRST_RST = 16'h1388;
    localparam logic [15:0] TMR_SECOND_RST = 16'h1388;
    localparam logic [15:0] TMR_CHECK_RST = 16'h2710;
    localparam logic [11:0] GMAX_RST = 12'hfff;

    // timer tick: one millisecond at the system clock rate
    localparam int CLK_MHZ = 40;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // decoded auxiliary commands, each a one-cycle pulse
    typedef struct packed {
        logic first_spindle_cw_cmd;
        logic first_spindle_ccw_cmd;
        logic first_spindle_stop_cmd;
        logic second_spindle_cw_cmd;
        logic second_spindle_ccw_cmd;
        logic second_spindle_stop_cmd;
        logic [3:0] gear_select_cmd;
        logic [3:0] gear_out_cmd;
        logic gear_cancel_cmd;
    } ssg_cmd_t;

    // spindle rotation outputs
    typedef struct packed {
        logic first_cw;
        logic first_ccw;
        logic second_cw;
        logic second_ccw;
    } ssg_rot_t;

    // panel lamps
    typedef struct packed {
        logic ccw;
        logic stop;
        logic cw;
    } ssg_lamp_t;

    typedef enum logic [1:0] {SH_IDLE, SH_RELEASE, SH_WAIT, SH_SETTLE} ssg_shift_st_t;

endpackage

//--- ssg_sequencer.sv
// spindle selection, automatic gear shifting and switched gear outputs
// assumes command pulses and feedback inputs synchronous to i_clk
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: first spindle selected after power-on
// RULE2: first spindle command selects and drives it
// RULE3: second spindle command switches and drives it
// RULE4: separate stop commands per spindle
// RULE5: lamps follow first spindle only
// RULE6: second spindle only in analog mode
// RULE7: opposite second command while rotating raises alarm
// RULE8: switching to rotating spindle needs same direction
// RULE9: estop or alarm stops all, asserts stop
// RULE10: auto shift only when enable bit set
// RULE11: hold bit keeps gear output after shift
// RULE12: shift starts only for a different gear
// RULE13: shift start outputs configured shifting speed
// RULE14: first timer then swap gear outputs
// RULE15: missing in-position within check time alarms
// RULE16: second delay then per-gear maximum speed
// RULE17: both shift timers default five seconds
// RULE18: gear select while disabled raises alarm
// RULE19: mode bit picks analog or switched control
// RULE20: block bit ignores speed commands in estop
// RULE21: gear command asserts one, clears others
// RULE22: cancel clears all, one output at most
module ssg_sequencer #(
    parameter int TICK_CYCLES = ssg_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [ssg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ssg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ssg_pkg::DATA_W-1:0] o_rdata,
    // commands and feedback
    input wire ssg_pkg::ssg_cmd_t i_cmd,
    input wire logic i_estop,
    input wire logic i_spindle_alarm,
    input wire logic [3:0] i_gear_in_position,
    // drive outputs
    output ssg_pkg::ssg_rot_t o_rot,
    output logic o_spindle_stop,
    output ssg_pkg::ssg_lamp_t o_lamp,
    output logic [3:0] o_gear_stage_out,
    output logic [11:0] o_analog_speed,
    // state
    output logic o_second_selected,
    output logic o_shifting,
    output logic [3:0] o_alarm
);

    localparam int PRE_W = $clog2(TICK_CYCLES);

    // index of the lowest set bit; commands are one-hot, extras are ignored
    function automatic logic [1:0] onehot_idx(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        if (v[0]) r = 2'h0;
        else if (v[1]) r = 2'h1;
        else if (v[2]) r = 2'h2;
        else if (v[3]) r = 2'h3;
        return r;
    endfunction

    // gear index to a single output line
    function automatic logic [3:0] gear_dec(input logic [1:0] idx);
        return 4'h1 << idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [3:0] ctrl_q;
    logic [11:0] shift_speed_q;
    logic [15:0] tmr_first_q;
    logic [15:0] tmr_second_q;
    logic [15:0] tmr_check_q;
    logic [11:0] gmax_q [4];
    logic [3:0] alarm_q;
    logic [3:0] alarm_d;
    logic [15:0] rdata_d;

    wire ctrl_auto = ctrl_q[ssg_pkg::CTRL_AUTO_BIT];
    wire ctrl_hold = ctrl_q[ssg_pkg::CTRL_HOLD_BIT];
    wire ctrl_analog = ctrl_q[ssg_pkg::CTRL_ANALOG_BIT];
    wire ctrl_block = ctrl_q[ssg_pkg::CTRL_BLOCK_BIT];

    // write decode
    wire wr_gmax = i_wr && i_addr >= ssg_pkg::REG_GMAX_FIRST && i_addr <= ssg_pkg::REG_GMAX_LAST;
    wire [3:0] gmax_off = i_addr - ssg_pkg::REG_GMAX_FIRST;
    wire [1:0] gmax_idx = gmax_off[1:0];
    wire wr_alarm = i_wr && i_addr == ssg_pkg::REG_ALARM;

    // configuration writes; shift timers default to five seconds, check timer to ten seconds
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= ssg_pkg::CTRL_RST;
            shift_speed_q <= ssg_pkg::SHIFT_SPEED_RST;
            tmr_first_q <= ssg_pkg::TMR_FIRST_RST; // RULE17
            tmr_second_q <= ssg_pkg::TMR_SECOND_RST; // RULE17
            tmr_check_q <= ssg_pkg::TMR_CHECK_RST;
        end else if (i_wr) begin
            if (i_addr == ssg_pkg::REG_CTRL) ctrl_q <= i_wdata[3:0];
            if (i_addr == ssg_pkg::REG_SHIFT_SPEED) shift_speed_q <= i_wdata[11:0];
            if (i_addr == ssg_pkg::REG_TMR_FIRST) tmr_first_q <= i_wdata;
            if (i_addr == ssg_pkg::REG_TMR_SECOND) tmr_second_q <= i_wdata;
            if (i_addr == ssg_pkg::REG_TMR_CHECK) tmr_check_q <= i_wdata;
        end
    end

    // per-gear maximum speed table
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 4; i++) gmax_q[i] <= ssg_pkg::GMAX_RST;
        end else if (wr_gmax) begin
            gmax_q[gmax_idx] <= i_wdata[11:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // spindle selection and rotation
    ssg_pkg::ssg_rot_t rot_q;
    ssg_pkg::ssg_rot_t rot_d;
    logic sel_q;
    logic stop_q;
    ssg_pkg::ssg_lamp_t lamp_q;

    wire halt = i_estop | i_spindle_alarm;
    wire cw1 = i_cmd.first_spindle_cw_cmd;
    wire ccw1 = i_cmd.first_spindle_ccw_cmd;
    wire cw2 = i_cmd.second_spindle_cw_cmd & ctrl_analog; // RULE6
    wire ccw2 = i_cmd.second_spindle_ccw_cmd & ctrl_analog; // RULE6
    wire stop1 = i_cmd.first_spindle_stop_cmd;
    wire stop2 = i_cmd.second_spindle_stop_cmd;

    // an opposite request on a rotating spindle is refused, never reversed on the fly
    wire opp1 = (cw1 & rot_q.first_ccw) | (ccw1 & rot_q.first_cw);
    wire opp2 = (cw2 & rot_q.second_ccw) | (ccw2 & rot_q.second_cw);
    wire take_cw1 = cw1 & ~opp1 & ~halt;
    wire take_ccw1 = ccw1 & ~opp1 & ~halt;
    wire take_cw2 = cw2 & ~opp2 & ~halt & ~(cw1 | ccw1);
    wire take_ccw2 = ccw2 & ~opp2 & ~halt & ~(cw1 | ccw1);
    wire dir_alarm = opp2 & sel_q & ~halt; // RULE7
    wire wrong_alarm = ((opp2 & ~sel_q) | (opp1 & sel_q)) & ~halt; // RULE8

    // next rotation state: halt clears both spindles at once
    always_comb begin
        rot_d = rot_q;
        if (halt) begin
            rot_d = '0; // RULE9
        end else begin
            if (stop1) begin
                rot_d.first_cw = 1'b0; // RULE4
                rot_d.first_ccw = 1'b0;
            end else if (take_cw1 | take_ccw1) begin
                rot_d.first_cw = take_cw1; // RULE2
                rot_d.first_ccw = take_ccw1;
            end
            if (stop2) begin
                rot_d.second_cw = 1'b0; // RULE4
                rot_d.second_ccw = 1'b0;
            end else if (take_cw2 | take_ccw2) begin
                rot_d.second_cw = take_cw2; // RULE3
                rot_d.second_ccw = take_ccw2;
            end
        end
    end

    // stop output and lamps registered with the rotation outputs so they never disagree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rot_q <= '0;
            sel_q <= 1'b0; // RULE1
            stop_q <= 1'b1;
            lamp_q <= 3'h2;
        end else begin
            rot_q <= rot_d;
            if (take_cw1 | take_ccw1) sel_q <= 1'b0; // RULE2
            else if (take_cw2 | take_ccw2) sel_q <= 1'b1; // RULE3
            stop_q <= ~(|rot_d); // RULE9
            lamp_q <= {rot_d.first_ccw, ~(rot_d.first_cw | rot_d.first_ccw), rot_d.first_cw}; // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // millisecond timebase and state timer
    logic [PRE_W-1:0] pre_q;
    logic [15:0] ms_q;
    ssg_pkg::ssg_shift_st_t st_q;
    ssg_pkg::ssg_shift_st_t st_d;
    wire tick = pre_q == PRE_W'(TICK_CYCLES - 1);
    wire [15:0] limit = (st_q == ssg_pkg::SH_RELEASE) ? tmr_first_q :
                        (st_q == ssg_pkg::SH_SETTLE) ? tmr_second_q : tmr_check_q;
    wire elapsed = ms_q >= limit;

    // timer restarts on every state change, saturates at full scale
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_q <= '0;
            ms_q <= 16'h0;
        end else begin
            pre_q <= tick ? '0 : pre_q + 1'b1;
            if (st_d != st_q) ms_q <= 16'h0;
            else if (tick && ms_q != 16'hffff) ms_q <= ms_q + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // gear shift sequencer
    logic [1:0] cur_q;
    logic [1:0] tgt_q;
    logic [3:0] gear_q;
    logic [11:0] speed_q;

    wire spd_blocked = i_estop & ctrl_block; // RULE20
    wire auto_ok = ctrl_auto & ctrl_analog; // RULE10
    wire sel_req = (|i_cmd.gear_select_cmd) & ~spd_blocked;
    wire [1:0] req_idx = onehot_idx(i_cmd.gear_select_cmd);
    wire idle = st_q == ssg_pkg::SH_IDLE;
    wire shift_start = sel_req & auto_ok & idle & (req_idx != cur_q); // RULE12
    wire disabled_alarm = sel_req & ~auto_ok; // RULE18
    wire in_pos = i_gear_in_position[cur_q];
    wire timeout_alarm = (st_q == ssg_pkg::SH_WAIT) & ~in_pos & elapsed; // RULE15
    // switched control only when the analog mode bit is clear
    wire sw_mode = ~ctrl_analog & idle & ~spd_blocked; // RULE19
    wire sw_set = sw_mode & (|i_cmd.gear_out_cmd);
    wire sw_cancel = sw_mode & i_cmd.gear_cancel_cmd;

    // state transitions
    always_comb begin
        st_d = st_q;
        case (st_q)
            ssg_pkg::SH_IDLE: begin
                if (shift_start) st_d = ssg_pkg::SH_RELEASE;
            end
            ssg_pkg::SH_RELEASE: begin
                if (elapsed) st_d = ssg_pkg::SH_WAIT; // RULE14
            end
            ssg_pkg::SH_WAIT: begin
                if (in_pos) st_d = ssg_pkg::SH_SETTLE;
                else if (elapsed) st_d = ssg_pkg::SH_IDLE; // RULE15
            end
            ssg_pkg::SH_SETTLE: begin
                if (elapsed) st_d = ssg_pkg::SH_IDLE; // RULE16
            end
            default: st_d = ssg_pkg::SH_IDLE;
        endcase
    end

    // gear outputs and analog speed; cancel is checked first so one line at most stands
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ssg_pkg::SH_IDLE;
            cur_q <= 2'h0;
            tgt_q <= 2'h0;
            gear_q <= 4'h0; // RULE21
            speed_q <= 12'h0;
        end else begin
            st_q <= st_d;
            if (shift_start) begin
                tgt_q <= req_idx;
                speed_q <= shift_speed_q; // RULE13
            end
            if (st_q == ssg_pkg::SH_RELEASE && elapsed) begin
                cur_q <= tgt_q;
                gear_q <= gear_dec(tgt_q); // RULE14
            end
            if (st_q == ssg_pkg::SH_SETTLE && elapsed) begin
                speed_q <= gmax_q[cur_q]; // RULE16
                if (!ctrl_hold) gear_q <= 4'h0; // RULE11
            end
            if (sw_cancel) gear_q <= 4'h0; // RULE22
            else if (sw_set) gear_q <= gear_dec(onehot_idx(i_cmd.gear_out_cmd)); // RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // sticky alarms: a new event in the clearing cycle survives the clear
    wire [3:0] alarm_set = {disabled_alarm, timeout_alarm, wrong_alarm, dir_alarm};
    assign alarm_d = (alarm_q & ~(wr_alarm ? i_wdata[3:0] : 4'h0)) | alarm_set;

    // read mux
    always_comb begin
        rdata_d = 16'h0;
        if (i_addr == ssg_pkg::REG_CTRL) rdata_d = {12'h0, ctrl_q};
        else if (i_addr == ssg_pkg::REG_SHIFT_SPEED) rdata_d = {4'h0, shift_speed_q};
        else if (i_addr == ssg_pkg::REG_TMR_FIRST) rdata_d = tmr_first_q;
        else if (i_addr == ssg_pkg::REG_TMR_SECOND) rdata_d = tmr_second_q;
        else if (i_addr == ssg_pkg::REG_TMR_CHECK) rdata_d = tmr_check_q;
        else if (wr_gmax || (i_addr >= ssg_pkg::REG_GMAX_FIRST && i_addr <= ssg_pkg::REG_GMAX_LAST))
            rdata_d = {4'h0, gmax_q[gmax_idx]};
        else if (i_addr == ssg_pkg::REG_STATUS)
            rdata_d = {8'h0, gear_q, cur_q, ~idle, sel_q};
        else if (i_addr == ssg_pkg::REG_ALARM) rdata_d = {12'h0, alarm_q};
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            alarm_q <= 4'h0;
            o_rdata <= 16'h0;
        end else begin
            alarm_q <= alarm_d;
            o_rdata <= i_rd ? rdata_d : 16'h0;
        end
    end

    // outputs
    assign o_rot = rot_q;
    assign o_spindle_stop = stop_q;
    assign o_lamp = lamp_q;
    assign o_gear_stage_out = gear_q;
    assign o_analog_speed = speed_q;
    assign o_second_selected = sel_q;
    assign o_shifting = ~idle;
    assign o_alarm = alarm_q;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence shift_begin;
        shift_start;
    endsequence
    sequence release_done;
        st_q == ssg_pkg::SH_RELEASE && elapsed;
    endsequence
    sequence settle_done;
        st_q == ssg_pkg::SH_SETTLE && elapsed;
    endsequence

    halt_stops_a: assert property (halt |=> o_rot == '0 && o_spindle_stop) // RULE9
        else $error("rotation left on after halt");
    first_run_a: assert property ((cw1 && !halt && !stop1 && !rot_q.first_ccw) // RULE2
        |=> o_rot.first_cw && !o_second_selected)
        else $error("first spindle cw not taken");
    second_run_a: assert property ((cw2 && !halt && !stop2 && !rot_q.second_ccw // RULE3
        && !cw1 && !ccw1) |=> o_rot.second_cw && o_second_selected)
        else $error("second spindle cw not taken");
    stop_first_a: assert property ((stop1 && !stop2 && !halt && !take_cw2 && !take_ccw2) // RULE4
        |=> !o_rot.first_cw && !o_rot.first_ccw && $stable(o_rot.second_cw))
        else $error("first stop misapplied");
    lamp_track_a: assert property (o_lamp.cw == o_rot.first_cw // RULE5
        && o_lamp.ccw == o_rot.first_ccw && o_lamp.stop == !(o_rot.first_cw || o_rot.first_ccw))
        else $error("lamps disagree with first spindle");
    digital_mode_a: assert property ((!ctrl_analog && !halt && !stop2) // RULE6
        |=> $stable(o_rot.second_cw) && $stable(o_rot.second_ccw))
        else $error("second spindle moved outside analog mode");
    dir_alarm_a: assert property ((sel_q && rot_q.second_cw && ccw2 && !halt && !stop2) // RULE7
        |=> o_alarm[ssg_pkg::ALM_DIR_BIT] && o_rot.second_cw)
        else $error("direction alarm missing");
    wrong_rot_a: assert property ((!sel_q && !halt && ((rot_q.second_ccw && cw2) // RULE8
        || (rot_q.second_cw && ccw2))) |=> o_alarm[ssg_pkg::ALM_WRONG_BIT] && !o_second_selected)
        else $error("wrong rotation alarm missing");
    shift_enable_a: assert property ($rose(o_shifting) |-> $past(auto_ok && req_idx != cur_q)) // RULE10
        else $error("shift without enable or same gear");
    shift_speed_a: assert property (shift_begin |=> o_shifting // RULE13
        && o_analog_speed == $past(shift_speed_q))
        else $error("shifting speed not output");
    gear_swap_a: assert property (release_done |=> st_q == ssg_pkg::SH_WAIT // RULE14
        && o_gear_stage_out == gear_dec($past(tgt_q)))
        else $error("gear output not swapped");
    timeout_a: assert property ((st_q == ssg_pkg::SH_WAIT && elapsed && !in_pos) // RULE15
        |=> o_alarm[ssg_pkg::ALM_TIMEOUT_BIT] && !o_shifting)
        else $error("shift timeout alarm missing");
    finish_a: assert property (settle_done |=> !o_shifting // RULE16
        && o_analog_speed == $past(gmax_q[cur_q]))
        else $error("max speed not output after shift");
    hold_off_a: assert property ((settle_done and !ctrl_hold and !sw_mode) // RULE11
        |=> o_gear_stage_out == 4'h0)
        else $error("gear output kept without hold");
    disabled_a: assert property (disabled_alarm |=> o_alarm[ssg_pkg::ALM_DISABLED_BIT] // RULE18
        && !$rose(o_shifting))
        else $error("disabled shift alarm missing");
    one_gear_a: assert property ($onehot0(o_gear_stage_out)) // RULE22
        else $error("more than one gear output");
    cancel_a: assert property (sw_cancel |=> o_gear_stage_out == 4'h0) // RULE22
        else $error("cancel left a gear output");
    block_a: assert property ((spd_blocked && idle) |=> $stable(o_gear_stage_out) // RULE20
        && !o_shifting)
        else $error("speed command taken in blocked estop");
    set_gear_a: assert property ((sw_set && !sw_cancel) |=> o_gear_stage_out // RULE21
        == gear_dec($past(onehot_idx(i_cmd.gear_out_cmd))))
        else $error("switched gear output wrong");

endmodule

`default_nettype wire

//--- ssg_gearbox_model.sv
// gearbox position switches facing the gear stage outputs
// assumes it shares i_clk with the sequencer and sits in gear one at power-on
`timescale 1ns/1ps
`default_nettype none

module ssg_gearbox_model #(
    parameter int DELAY = 4
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // gear stage drive and fault control
    input wire logic [3:0] i_gear_stage_out,
    input wire logic i_mute,
    output logic [3:0] o_in_position
);
    logic [3:0] last_q;
    logic [3:0] pos_q;
    logic [7:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // a new stage drops the switches while the gears move; a released stage keeps
    // the last gear engaged, as the mechanics would; mute models a jammed shift
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_q <= 4'h0;
            pos_q <= 4'h1;
            cnt_q <= 8'h00;
        end else if (i_gear_stage_out != 4'h0 && i_gear_stage_out != last_q) begin
            last_q <= i_gear_stage_out;
            pos_q <= 4'h0;
            cnt_q <= 8'h00;
        end else if (last_q != 4'h0 && cnt_q < 8'(DELAY)) begin
            cnt_q <= cnt_q + 8'h01;
        end else if (last_q != 4'h0 && !i_mute) begin
            pos_q <= last_q;
        end
    end
    assign o_in_position = pos_q;
endmodule
`default_nettype wire

//--- ssg_sequencer_tb_top.sv
// self-checking bench of the spindle select and gear sequencer
// assumes the sequencer is built with a short tick so timers run in a few cycles
`timescale 1ns/1ps
`default_nettype none

module ssg_sequencer_tb_top;
    typedef struct packed {
        logic [14:0] cmd;
        logic [3:0] rot;
        logic [2:0] lamp;
        logic sel;
        logic [3:0] alm;
    } ssg_row_t;
    logic i_clk, i_rst, i_wr, i_rd, i_estop, i_spindle_alarm, i_mute;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, rv;
    ssg_pkg::ssg_cmd_t i_cmd;
    logic [3:0] i_gear_in_position, o_gear_stage_out, o_alarm;
    ssg_pkg::ssg_rot_t o_rot;
    ssg_pkg::ssg_lamp_t o_lamp;
    logic o_spindle_stop, o_second_selected, o_shifting;
    logic [11:0] o_analog_speed;
    int bad_count = 0;
    int compares = 0;
    int n;
    // rotation commands in order; x in sel means selection is not judged
    ssg_row_t rows [9] = '{'{15'h4000, 4'h8, 3'h1, 1'b0, 4'h0}, '{15'h1000, 4'h0, 3'h2, 1'b0, 4'h0},
        '{15'h2000, 4'h4, 3'h4, 1'b0, 4'h0}, '{15'h0800, 4'h6, 3'h4, 1'b1, 4'h0},
        '{15'h0400, 4'h6, 3'h4, 1'b1, 4'h1}, '{15'h2000, 4'h6, 3'h4, 1'b0, 4'h1},
        '{15'h0400, 4'h6, 3'h4, 1'bx, 4'h3}, '{15'h0200, 4'h4, 3'h4, 1'bx, 4'h3},
        '{15'h1000, 4'h0, 3'h2, 1'bx, 4'h3}};

    ssg_sequencer #(.TICK_CYCLES(4)) i_ssg_sequencer (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cmd(i_cmd), .i_estop(i_estop), .i_spindle_alarm(i_spindle_alarm),
        .i_gear_in_position(i_gear_in_position), .o_rot(o_rot), .o_spindle_stop(o_spindle_stop),
        .o_lamp(o_lamp), .o_gear_stage_out(o_gear_stage_out), .o_analog_speed(o_analog_speed),
        .o_second_selected(o_second_selected), .o_shifting(o_shifting), .o_alarm(o_alarm));
    ssg_gearbox_model #(.DELAY(4)) i_ssg_gearbox_model (.i_clk(i_clk), .i_rst(i_rst),
        .i_gear_stage_out(o_gear_stage_out), .i_mute(i_mute), .o_in_position(i_gear_in_position));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, comparison and bus tasks
    always #12.5 i_clk = ~i_clk;
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
        @(negedge i_clk) d = o_rdata;
    endtask
    // one-cycle command pulse, outputs judged once its answer has landed
    task automatic pulse(input logic [14:0] c);
        @(posedge i_clk) i_cmd <= c;
        @(posedge i_clk) i_cmd <= '0;
        @(negedge i_clk);
    endtask
    // bounded wait: 0 gear outputs, 1 shifting flag, 2 alarms equal v
    task automatic wait_for(input int sel, input logic [3:0] v, output int cnt);
        for (cnt = 0; cnt < 400; cnt++) begin
            if ((sel == 0 && o_gear_stage_out === v) || (sel == 1 && o_shifting === v[0])
                || (sel == 2 && o_alarm === v)) return;
            @(negedge i_clk);
        end
        bad_count++;
        end_sim();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {i_clk, i_wr, i_rd, i_estop, i_spindle_alarm, i_mute, i_addr, i_wdata} = '0;
        i_cmd = '0;
        i_rst = 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        check(16'({o_rot, o_spindle_stop, o_lamp, o_gear_stage_out}), 16'h00a0);
        rd(ssg_pkg::REG_TMR_FIRST, rv);
        check(rv, 16'h1388);
        rd(ssg_pkg::REG_TMR_SECOND, rv);
        check(rv, 16'h1388);
        rd(4'hb, rv);
        check(rv, 16'h0000);
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            pulse(rows[k].cmd);
            check(16'(o_rot), 16'(rows[k].rot));
            check(16'(o_lamp), 16'(rows[k].lamp));
            check(16'(o_spindle_stop), 16'(o_rot == 4'h0));
            check(16'(o_alarm), 16'(rows[k].alm));
            if (rows[k].sel !== 1'bx) check(16'(o_second_selected), 16'(rows[k].sel));
        end
        wr(ssg_pkg::REG_ALARM, 16'h000f);
        $display("test rotation done");
        for (int h = 0; h < 2; h++) begin
            pulse(15'h4000);
            @(posedge i_clk) {i_estop, i_spindle_alarm} <= (h == 0) ? 2'b10 : 2'b01;
            pulse(15'h0800);
            check(16'({o_rot, o_spindle_stop}), 16'h0001);
            @(posedge i_clk) {i_estop, i_spindle_alarm} <= 2'b00;
        end
        $display("test halt done");
        pulse(15'h0040);
        check(16'({o_alarm, 3'h0, o_shifting}), 16'h0080);
        wr(ssg_pkg::REG_ALARM, 16'h000f);
        wr(ssg_pkg::REG_CTRL, 16'h0000);
        pulse(15'h0800);
        check(16'(o_rot), 16'h0000);
        for (int g = 0; g < 4; g++) begin
            pulse(15'h0002 << g);
            check(16'(o_gear_stage_out), 16'h0001 << g);
        end
        pulse(15'h0001);
        check(16'(o_gear_stage_out), 16'h0000);
        wr(ssg_pkg::REG_CTRL, 16'h0008);
        @(posedge i_clk) i_estop <= 1'b1;
        pulse(15'h0004);
        check(16'(o_gear_stage_out), 16'h0000);
        wr(ssg_pkg::REG_CTRL, 16'h0000);
        pulse(15'h0004);
        check(16'(o_gear_stage_out), 16'h0002);
        @(posedge i_clk) i_estop <= 1'b0;
        pulse(15'h0001);
        $display("test switched gears done");
        wr(ssg_pkg::REG_CTRL, 16'h0005);
        wr(ssg_pkg::REG_SHIFT_SPEED, 16'h0123);
        wr(ssg_pkg::REG_TMR_FIRST, 16'h0003);
        wr(ssg_pkg::REG_TMR_SECOND, 16'h0002);
        wr(ssg_pkg::REG_TMR_CHECK, 16'h0014);
        wr(4'h6, 16'h00ab);
        pulse(15'h0020);
        check(16'(o_shifting), 16'h0000);
        pulse(15'h0040);
        check(16'({o_shifting, o_analog_speed}), 16'h1123);
        wait_for(0, 4'h2, n);
        check(16'({n >= 7, o_shifting}), 16'h0003);
        wait_for(1, 4'h0, n);
        check(16'({o_gear_stage_out, o_analog_speed}), 16'h00ab);
        wr(ssg_pkg::REG_CTRL, 16'h0007);
        pulse(15'h0080);
        wait_for(1, 4'h0, n);
        check(16'({o_gear_stage_out, o_analog_speed}), 16'h4fff);
        @(posedge i_clk) i_mute <= 1'b1;
        pulse(15'h0100);
        wait_for(2, 4'h4, n);
        wait_for(1, 4'h0, n);
        check(16'({o_alarm, o_analog_speed}), 16'h4123);
        $display("test auto shift done");
        end_sim();
    end
endmodule
`default_nettype wire
